// ===== rtl/sem_rx_monitor.sv
// Receive error monitor and status register block
`timescale 1ns/10ps
module sem_rx_monitor #(
    parameter int CNT_W  = 16,
    parameter int EVT_W  = 8,
    parameter int DATA_W = 5
) (
    input  wire logic              CLK,
    input  wire logic              RST,
    input  wire logic [7:0]        REG_ADDR,
    input  wire logic              REG_WR,
    input  wire logic [7:0]        REG_WDATA,
    input  wire logic              REG_RD,
    output logic      [7:0]        REG_RDATA,
    input  wire logic              CDR_LOCK,
    input  wire logic [2:0]        RATE_CODE,
    input  wire logic [1:0]        SIG_DET,
    input  wire logic              CLK_LOSS,
    input  wire logic              CODE_ERR,
    input  wire logic              DATA_ERR,
    input  wire logic              WINDOW_TICK,
    input  wire logic              EVT_COUNT_EN,
    input  wire logic              EVT_SEL,
    input  wire logic [DATA_W-1:0] RX_DATA,
    input  wire logic              RX_VALID,
    output logic [DATA_W-1:0]      PARALLEL_DATA_OUTPUTS,
    output logic                   PAR_VALID,
    output logic                   LINK_ACQ,
    output logic                   RX_NORMAL
);

    // Asynchronous pins: lock, rate, two signal detects, clock loss
    localparam int SYNC_W = 7;

    // Control registers
    logic [7:0]        ctrl_ff;
    logic [7:0]        thr_low_ff;
    logic [7:0]        thr_high_ff;
    logic [7:0]        nxt_ctrl;
    logic [7:0]        nxt_thr_low;
    logic [7:0]        nxt_thr_high;

    // Synchronisers and derived status
    logic [SYNC_W-1:0] sync1_ff;
    logic [SYNC_W-1:0] sync2_ff;
    logic              lock_s;
    logic [2:0]        rate_s;
    logic [1:0]        sig_det_s;
    logic              clk_loss_s;
    logic              lock_d_ff;
    logic              clk_loss_d_ff;
    logic [2:0]        rate_ff;

    // State and event counters
    sem_pkg::sem_state_t state_ff;
    sem_pkg::sem_state_t nxt_state;
    logic [EVT_W-1:0]  cdr_evt_ff;
    logic [EVT_W-1:0]  data_evt_ff;
    logic [EVT_W-1:0]  nxt_cdr_evt;
    logic [EVT_W-1:0]  nxt_data_evt;

    // Output registers
    logic [7:0]        rdata_ff;
    logic [DATA_W-1:0] pdata_ff;
    logic              pvalid_ff;
    logic              link_ff;
    logic              normal_ff;

    // Decoded controls and events
    logic              wr_ctrl;
    logic              wr_thr_low;
    logic              wr_thr_high;
    logic              wr_evt;
    logic              wr_cnt;
    logic              accum;
    logic              code_dis;
    logic              clr_cnt;
    logic              cnt_sel;
    logic              exit_dis;
    logic              code_err_eff;
    logic [15:0]       threshold;
    logic              over_thr;
    logic              lock_fall;
    logic              clk_loss_rise;
    logic              cdr_event;
    logic              data_event;
    logic              run_start;
    logic              link_good;
    logic [7:0]        rd_mux;

    sem_cnt_if #(.W(CNT_W)) cif ();

    sem_err_counter #(
        .W   (CNT_W)
    ) u_err_counter (
        .clk (CLK),
        .rst (RST),
        .cif (cif.cnt)
    );

    // Address decode shared by write and read paths
    function automatic logic hit(input logic [7:0] a, input logic [7:0] o);
        hit = (a == o);
    endfunction

    // Event counters hold at full scale rather than wrap to zero
    function automatic logic [EVT_W-1:0] evt_inc(input logic [EVT_W-1:0] v,
                                                 input logic            ev);
        evt_inc = (ev && !(&v)) ? v + {{(EVT_W-1){1'b0}}, 1'b1} : v;
    endfunction

    // Register writes
    assign wr_ctrl     = REG_WR && hit(REG_ADDR, sem_pkg::ADDR_ERR_MON_CTRL);
    assign wr_thr_low  = REG_WR && hit(REG_ADDR, sem_pkg::ADDR_ERR_THR_LOW);
    assign wr_thr_high = REG_WR && hit(REG_ADDR, sem_pkg::ADDR_ERR_THR_HIGH);
    assign wr_evt      = REG_WR && hit(REG_ADDR, sem_pkg::ADDR_LINK_LOSS_CNT);
    assign wr_cnt      = REG_WR && (hit(REG_ADDR, sem_pkg::ADDR_DATA_ERR_LOW)
                         || hit(REG_ADDR, sem_pkg::ADDR_DATA_ERR_HIGH));

    assign nxt_ctrl     = wr_ctrl ? (REG_WDATA & sem_pkg::CTRL_WR_MASK)
                                  : ctrl_ff;
    assign nxt_thr_low  = wr_thr_low ? REG_WDATA : thr_low_ff;
    assign nxt_thr_high = wr_thr_high ? REG_WDATA : thr_high_ff;

    // Control fields
    assign accum    = ctrl_ff[sem_pkg::BIT_ACCUMULATE];
    assign code_dis = ctrl_ff[sem_pkg::BIT_CODE_ERR_DIS];
    assign clr_cnt  = ctrl_ff[sem_pkg::BIT_CLEAR_COUNT];
    assign cnt_sel  = ctrl_ff[sem_pkg::BIT_COUNT_SELECT];
    assign exit_dis = ctrl_ff[sem_pkg::BIT_NORM_EXIT_DIS];

    // Synchronised pin levels
    assign lock_s     = sync2_ff[0];
    assign rate_s     = sync2_ff[3:1];
    assign sig_det_s  = sync2_ff[5:4];
    assign clk_loss_s = sync2_ff[6];

    // Masked code violations
    assign code_err_eff = CODE_ERR && !code_dis;

    // Error counter hookup
    assign cif.clr      = clr_cnt || wr_cnt;
    assign cif.err      = DATA_ERR || code_err_eff;
    assign cif.restart  = run_start;
    assign cif.win_tick = WINDOW_TICK;
    assign cif.accum    = accum;
    assign cif.sel      = cnt_sel;

    // Threshold test on the count that is shown
    assign threshold = {thr_high_ff, thr_low_ff};
    assign over_thr  = cif.shown > threshold;

    // Link-loss events
    assign lock_fall     = lock_d_ff && !lock_s;
    assign clk_loss_rise = clk_loss_s && !clk_loss_d_ff;
    assign cdr_event     = lock_fall || clk_loss_rise;
    assign data_event    = (state_ff == sem_pkg::ST_NORMAL)
                           && (nxt_state == sem_pkg::ST_HALTED);
    assign run_start     = (state_ff != sem_pkg::ST_NORMAL)
                           && (nxt_state == sem_pkg::ST_NORMAL);

    // Counting gated by enable; a register write clears the shown counter
    assign nxt_cdr_evt  = (wr_evt && !EVT_SEL) ? '0 :
                          (EVT_COUNT_EN ? evt_inc(cdr_evt_ff, cdr_event)
                                        : cdr_evt_ff);
    assign nxt_data_evt = (wr_evt && EVT_SEL) ? '0 :
                          (EVT_COUNT_EN ? evt_inc(data_evt_ff, data_event)
                                        : data_evt_ff);

    // Receive state machine
    always_comb begin
        nxt_state = state_ff;
        case (state_ff)
            sem_pkg::ST_ACQUIRE: begin
                if (lock_s && !code_err_eff) begin
                    nxt_state = sem_pkg::ST_NORMAL;
                end
            end
            sem_pkg::ST_NORMAL: begin
                if (!lock_s) begin
                    nxt_state = sem_pkg::ST_ACQUIRE;
                end else if (over_thr && !exit_dis) begin
                    nxt_state = sem_pkg::ST_HALTED;
                end
            end
            sem_pkg::ST_HALTED: begin
                // Leave only once lock drops or software sets the clear-count control bit
                if (!lock_s || clr_cnt) begin
                    nxt_state = sem_pkg::ST_ACQUIRE;
                end
            end
            default: begin
                nxt_state = sem_pkg::ST_ACQUIRE;
            end
        endcase
    end

    // Link is good only in normal state, locked, free of live violations
    assign link_good = (state_ff == sem_pkg::ST_NORMAL) && lock_s
                       && !code_err_eff;

    // Read mux; unmapped and reserved bits read zero
    always_comb begin
        rd_mux = 8'h00;
        if (hit(REG_ADDR, sem_pkg::ADDR_ERR_MON_CTRL)) begin
            rd_mux = ctrl_ff;
        end else if (hit(REG_ADDR, sem_pkg::ADDR_ERR_THR_LOW)) begin
            rd_mux = thr_low_ff;
        end else if (hit(REG_ADDR, sem_pkg::ADDR_ERR_THR_HIGH)) begin
            rd_mux = thr_high_ff;
        end else if (hit(REG_ADDR, sem_pkg::ADDR_RATE_STATUS)) begin
            rd_mux[sem_pkg::RATE_LSB +: 3] = rate_ff;
        end else if (hit(REG_ADDR, sem_pkg::ADDR_LOCK_STATUS)) begin
            rd_mux[sem_pkg::BIT_CDR_LOCK] = lock_s;
            rd_mux[sem_pkg::BIT_SIG_DET_LSB +: 2] = sig_det_s;
        end else if (hit(REG_ADDR, sem_pkg::ADDR_LINK_LOSS_CNT)) begin
            rd_mux = EVT_SEL ? data_evt_ff : cdr_evt_ff;
        end else if (hit(REG_ADDR, sem_pkg::ADDR_DATA_ERR_LOW)) begin
            rd_mux = cif.shown[7:0];
        end else if (hit(REG_ADDR, sem_pkg::ADDR_DATA_ERR_HIGH)) begin
            rd_mux = cif.shown[15:8];
        end
    end

    // Pin synchronisers; first stage feeds only the second
    always_ff @(posedge CLK) begin
        if (RST) begin
            sync1_ff <= '0;
            sync2_ff <= '0;
        end else begin
            sync1_ff <= {CLK_LOSS, SIG_DET, RATE_CODE, CDR_LOCK};
            sync2_ff <= sync1_ff;
        end
    end

    always_ff @(posedge CLK) begin
        if (RST) begin
            lock_d_ff     <= 1'b0;
            clk_loss_d_ff <= 1'b0;
            rate_ff       <= sem_pkg::RATE_UNLOCKED;
        end else begin
            lock_d_ff     <= lock_s;
            clk_loss_d_ff <= clk_loss_s;
            rate_ff       <= lock_s ? rate_s : sem_pkg::RATE_UNLOCKED;
        end
    end

    always_ff @(posedge CLK) begin
        if (RST) begin
            ctrl_ff     <= sem_pkg::RST_ERR_MON_CTRL;
            thr_low_ff  <= sem_pkg::RST_ERR_THR_LOW;
            thr_high_ff <= sem_pkg::RST_ERR_THR_HIGH;
            cdr_evt_ff  <= sem_pkg::RST_EVENT_COUNT;
            data_evt_ff <= sem_pkg::RST_EVENT_COUNT;
            state_ff    <= sem_pkg::ST_ACQUIRE;
        end else begin
            ctrl_ff     <= nxt_ctrl;
            thr_low_ff  <= nxt_thr_low;
            thr_high_ff <= nxt_thr_high;
            cdr_evt_ff  <= nxt_cdr_evt;
            data_evt_ff <= nxt_data_evt;
            state_ff    <= nxt_state;
        end
    end

    // Output stage; data is blocked outside normal receive
    always_ff @(posedge CLK) begin
        if (RST) begin
            rdata_ff  <= 8'h00;
            pdata_ff  <= '0;
            pvalid_ff <= 1'b0;
            link_ff   <= 1'b0;
            normal_ff <= 1'b0;
        end else begin
            if (REG_RD) begin
                rdata_ff <= rd_mux;
            end
            pdata_ff  <= (state_ff == sem_pkg::ST_NORMAL) ? RX_DATA : '0;
            pvalid_ff <= (state_ff == sem_pkg::ST_NORMAL) && RX_VALID;
            link_ff   <= link_good;
            normal_ff <= (state_ff == sem_pkg::ST_NORMAL);
        end
    end

    assign REG_RDATA             = rdata_ff;
    assign PARALLEL_DATA_OUTPUTS = pdata_ff;
    assign PAR_VALID             = pvalid_ff;
    assign LINK_ACQ              = link_ff;
    assign RX_NORMAL             = normal_ff;

endmodule

// ===== rtl/sem_pkg.sv
// Package: register map, field positions, reset values and states
package sem_pkg;

    // Register offsets on the management port
    localparam logic [7:0] ADDR_ERR_MON_CTRL  = 8'h2D;
    localparam logic [7:0] ADDR_ERR_THR_LOW   = 8'h2E;
    localparam logic [7:0] ADDR_ERR_THR_HIGH  = 8'h2F;
    localparam logic [7:0] ADDR_RATE_STATUS   = 8'h3B;
    localparam logic [7:0] ADDR_LOCK_STATUS   = 8'h3C;
    localparam logic [7:0] ADDR_LINK_LOSS_CNT = 8'h3D;
    localparam logic [7:0] ADDR_DATA_ERR_LOW  = 8'h3E;
    localparam logic [7:0] ADDR_DATA_ERR_HIGH = 8'h3F;

    // Field positions in error_monitor_control
    localparam int BIT_ACCUMULATE    = 4;
    localparam int BIT_CODE_ERR_DIS  = 3;
    localparam int BIT_CLEAR_COUNT   = 2;
    localparam int BIT_COUNT_SELECT  = 1;
    localparam int BIT_NORM_EXIT_DIS = 0;
    localparam logic [7:0] CTRL_WR_MASK = 8'h1F;

    // Field positions in the status registers
    localparam int RATE_LSB         = 4;
    localparam int BIT_CDR_LOCK     = 3;
    localparam int BIT_SIG_DET_LSB  = 1;

    // Reset values
    localparam logic [7:0] RST_ERR_MON_CTRL = 8'h00;
    localparam logic [7:0] RST_ERR_THR_LOW  = 8'h10;
    localparam logic [7:0] RST_ERR_THR_HIGH = 8'h00;
    localparam logic [7:0] RST_EVENT_COUNT  = 8'h00;

    // Recovered rate codes
    localparam logic [2:0] RATE_270M     = 3'h1;
    localparam logic [2:0] RATE_1G485    = 3'h3;
    localparam logic [2:0] RATE_2G97     = 3'h6;
    localparam logic [2:0] RATE_UNLOCKED = 3'h7;

    typedef enum logic [1:0] {
        ST_ACQUIRE,
        ST_NORMAL,
        ST_HALTED
    } sem_state_t;

endpackage

// ===== rtl/sem_cnt_if.sv
// Interface: control and result of the data error counter
`timescale 1ns/10ps
interface sem_cnt_if #(parameter int W = 16);
    logic         clr;
    logic         err;
    logic         restart;
    logic         win_tick;
    logic         accum;
    logic         sel;
    logic [W-1:0] shown;

    modport ctl (
        output clr,
        output err,
        output restart,
        output win_tick,
        output accum,
        output sel,
        input  shown
    );
    modport cnt (
        input  clr,
        input  err,
        input  restart,
        input  win_tick,
        input  accum,
        input  sel,
        output shown
    );
endinterface

// ===== rtl/sem_err_counter.sv
// Data error counter: current run count and timing window count
`timescale 1ns/10ps
module sem_err_counter #(
    parameter int W = 16
) (
    input wire logic clk,
    input wire logic rst,
    sem_cnt_if.cnt   cif
);

    logic [W-1:0] run_ff;
    logic [W-1:0] win_ff;
    logic [W-1:0] held_ff;
    logic [W-1:0] nxt_run;
    logic [W-1:0] nxt_win;

    // Saturate so a long error burst never wraps under the threshold
    function automatic logic [W-1:0] sat_inc(input logic [W-1:0] v);
        sat_inc = (&v) ? v : v + {{(W-1){1'b0}}, 1'b1};
    endfunction

    // New run restarts the count unless accumulation is on
    assign nxt_run = (cif.restart && !cif.accum) ? '0 :
                     cif.err ? sat_inc(run_ff) : run_ff;
    assign nxt_win = cif.err ? sat_inc(win_ff) : win_ff;

    always_ff @(posedge clk) begin
        if (rst || cif.clr) begin
            run_ff  <= '0;
            win_ff  <= '0;
            held_ff <= '0;
        end else begin
            run_ff <= nxt_run;
            if (cif.win_tick) begin
                held_ff <= nxt_win;
                win_ff  <= '0;
            end else begin
                win_ff <= nxt_win;
            end
        end
    end

    assign cif.shown = cif.sel ? held_ff : run_ff;

endmodule

// ===== testbench/sem_rx_monitor_asserts.sv
// Checker: port-level properties of the receive error monitor
`timescale 1ns/10ps
module sem_rx_monitor_asserts #(
    parameter int DATA_W = 5
) (
    input wire logic              CLK,
    input wire logic              RST,
    input wire logic [7:0]        REG_ADDR,
    input wire logic              REG_RD,
    input wire logic [7:0]        REG_RDATA,
    input wire logic              CDR_LOCK,
    input wire logic [DATA_W-1:0] RX_DATA,
    input wire logic              RX_VALID,
    input wire logic [DATA_W-1:0] PARALLEL_DATA_OUTPUTS,
    input wire logic              PAR_VALID,
    input wire logic              RX_NORMAL
);
    default clocking cb @(posedge CLK);
    endclocking
    default disable iff (RST);

    // Six cycles covers both sync stages plus the state register
    sequence lock_lost_s;
        !CDR_LOCK [*6];
    endsequence
    sequence lock_held_s;
        CDR_LOCK [*4];
    endsequence
    sequence rd_at_s(logic [7:0] a);
        REG_RD && REG_ADDR == a;
    endsequence

    rd_hold_a: assert property (
        !REG_RD && !$past(REG_RD) |=> $stable(REG_RDATA))
        else $error("read data moved without a read");
    ctrl_resv_a: assert property (
        rd_at_s(sem_pkg::ADDR_ERR_MON_CTRL) |-> ##1 REG_RDATA[7:5] == 3'h0)
        else $error("control reserved bits not zero");
    rate_unlock_a: assert property (
        !CDR_LOCK [*4] ##0 rd_at_s(sem_pkg::ADDR_RATE_STATUS)
        |-> ##1 REG_RDATA == 8'h70)
        else $error("rate not unlocked code");
    rate_fmt_a: assert property (
        rd_at_s(sem_pkg::ADDR_RATE_STATUS)
        |-> ##1 !REG_RDATA[7] && REG_RDATA[3:0] == 4'h0)
        else $error("rate reserved bits not zero");
    lock_bit_a: assert property (
        lock_held_s ##0 rd_at_s(sem_pkg::ADDR_LOCK_STATUS)
        |-> ##1 REG_RDATA[3])
        else $error("lock bit low while locked");
    unlock_bit_a: assert property (
        lock_lost_s ##0 rd_at_s(sem_pkg::ADDR_LOCK_STATUS)
        |-> ##1 !REG_RDATA[3])
        else $error("lock bit high while unlocked");
    loss_exit_a: assert property (
        lock_lost_s |-> !RX_NORMAL)
        else $error("normal state kept without lock");
    idle_out_a: assert property (
        !RX_NORMAL |-> !PAR_VALID && PARALLEL_DATA_OUTPUTS == '0)
        else $error("outputs active outside normal");
    fwd_word_a: assert property (
        RX_NORMAL && $past(RX_VALID)
        |-> PAR_VALID && PARALLEL_DATA_OUTPUTS == $past(RX_DATA))
        else $error("received word not forwarded");
    no_early_a: assert property (
        $rose(RX_NORMAL) |-> $past(CDR_LOCK, 4))
        else $error("normal entered before lock");
endmodule

bind sem_rx_monitor sem_rx_monitor_asserts #(.DATA_W(DATA_W)) chk_u (
    .CLK(CLK),
    .RST(RST),
    .REG_ADDR(REG_ADDR),
    .REG_RD(REG_RD),
    .REG_RDATA(REG_RDATA),
    .CDR_LOCK(CDR_LOCK),
    .RX_DATA(RX_DATA),
    .RX_VALID(RX_VALID),
    .PARALLEL_DATA_OUTPUTS(PARALLEL_DATA_OUTPUTS),
    .PAR_VALID(PAR_VALID),
    .RX_NORMAL(RX_NORMAL)
);

// ===== testbench/sem_fe_model.sv
// Far-side model: clock recovery front end and word source
`timescale 1ns/10ps
module sem_fe_model (
    input  wire logic  clk,
    output logic       cdr_lock,
    output logic [2:0] rate_code,
    output logic [1:0] sig_det,
    output logic       clk_loss,
    output logic       code_err,
    output logic       data_err,
    output logic       window_tick,
    output logic [4:0] rx_data,
    output logic       rx_valid
);
    initial begin
        cdr_lock = 1'b0;
        rate_code = 3'h7;
        sig_det = 2'h0;
        clk_loss = 1'b0;
        code_err = 1'b0;
        data_err = 1'b0;
        window_tick = 1'b0;
        rx_data = 5'h00;
        rx_valid = 1'b0;
    end

    // Unlocked words flip every cycle so stale data never looks valid
    always @(posedge clk) begin
        #1;
        rx_valid = cdr_lock;
        rx_data = cdr_lock ? rx_data + 5'h01 : ~rx_data;
    end

    task automatic set_lock(input logic on, input logic [2:0] rate);
        @(posedge clk);
        #1;
        cdr_lock = on;
        rate_code = on ? rate : 3'h7;
        sig_det = on ? 2'h3 : 2'h0;
    endtask

    // Kind 0 data error, 1 code violation, 2 window end
    task automatic pulse(input int kind);
        @(posedge clk);
        #1;
        data_err = (kind == 0);
        code_err = (kind == 1);
        window_tick = (kind == 2);
        @(posedge clk);
        #1;
        data_err = 1'b0;
        code_err = 1'b0;
        window_tick = 1'b0;
    endtask
endmodule

// ===== testbench/test_sdi_rx_error_monitor_status.sv
// Testbench: register and receive path checks of the error monitor
`timescale 1ns/10ps
module test_sdi_rx_error_monitor_status;
    logic       clk = 1'b0;
    logic       rst = 1'b1;
    logic [7:0] reg_addr = 8'h00;
    logic       reg_wr = 1'b0;
    logic [7:0] reg_wdata = 8'h00;
    logic       reg_rd = 1'b0;
    logic       evt_en = 1'b1;
    logic       evt_sel = 1'b1;
    wire  [7:0] reg_rdata;
    wire        lock, clk_loss, code_err, data_err, tick, rx_valid;
    wire  [2:0] rate;
    wire  [1:0] sig_det;
    wire  [4:0] rx_data, par_data;
    wire        par_valid, link_acq, rx_normal;
    int         bad_count = 0;
    int         n_tests = 0;
    logic [2:0] rates [3] = '{3'h1, 3'h3, 3'h6};

    initial begin
        forever #2 clk = ~clk;
    end

    sem_fe_model fe_u (.clk(clk), .cdr_lock(lock), .rate_code(rate),
        .sig_det(sig_det), .clk_loss(clk_loss), .code_err(code_err),
        .data_err(data_err), .window_tick(tick), .rx_data(rx_data),
        .rx_valid(rx_valid));

    sem_rx_monitor dut_u (.CLK(clk), .RST(rst), .REG_ADDR(reg_addr),
        .REG_WR(reg_wr), .REG_WDATA(reg_wdata), .REG_RD(reg_rd),
        .REG_RDATA(reg_rdata), .CDR_LOCK(lock), .RATE_CODE(rate),
        .SIG_DET(sig_det), .CLK_LOSS(clk_loss), .CODE_ERR(code_err),
        .DATA_ERR(data_err), .WINDOW_TICK(tick), .EVT_COUNT_EN(evt_en),
        .EVT_SEL(evt_sel), .RX_DATA(rx_data), .RX_VALID(rx_valid),
        .PARALLEL_DATA_OUTPUTS(par_data), .PAR_VALID(par_valid),
        .LINK_ACQ(link_acq), .RX_NORMAL(rx_normal));

    task automatic chk(input string what, input logic [7:0] exp,
                       input logic [7:0] got);
        n_tests++;
        if (got !== exp) begin
            bad_count++;
            $display("unexpected %s exp %h seen %h", what, exp, got);
        end
    endtask

    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge clk);
        #1;
        reg_addr = a;
        reg_wdata = d;
        reg_wr = 1'b1;
        @(posedge clk);
        #1;
        reg_wr = 1'b0;
    endtask

    // Data sampled one edge late; it holds until the next read
    task automatic rd(input logic [7:0] a, input logic [7:0] exp);
        @(posedge clk);
        #1;
        reg_addr = a;
        reg_rd = 1'b1;
        @(posedge clk);
        #1;
        reg_rd = 1'b0;
        @(posedge clk);
        #1;
        chk($sformatf("reg %h", a), exp, reg_rdata);
    endtask

    task automatic errs(input int n, input int kind);
        repeat (n) fe_u.pulse(kind);
    endtask

    task automatic wait_normal(input logic want);
        for (int i = 0; i < 30 && rx_normal !== want; i++) begin
            @(posedge clk);
            #1;
        end
        chk("rx_normal", {7'h0, want}, {7'h0, rx_normal});
    endtask

    task automatic report_and_stop;
        $display("checks %0d mismatches %0d", n_tests, bad_count);
        if (bad_count == 0 && n_tests > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask

    initial begin
        #(4 * 6000);
        bad_count++;
        report_and_stop;
    end

    initial begin
        repeat (16) @(posedge clk);
        #1;
        rst = 1'b0;
        rd(8'h2D, 8'h00);
        rd(8'h2E, 8'h10);
        rd(8'h2F, 8'h00);
        rd(8'h3D, 8'h00);
        rd(8'h3E, 8'h00);
        rd(8'h3F, 8'h00);
        rd(8'h3B, 8'h70);
        rd(8'h3C, 8'h00);
        rd(8'h00, 8'h00);
        wr(8'h2D, 8'hFF);
        rd(8'h2D, 8'h1F);
        wr(8'h2D, 8'h00);
        wr(8'h2F, 8'hAB);
        rd(8'h2F, 8'hAB);
        wr(8'h2F, 8'h00);
        wr(8'h3B, 8'h00);
        rd(8'h3B, 8'h70);
        $display("test reset and access done");
        foreach (rates[i]) begin
            fe_u.set_lock(1'b1, rates[i]);
            wait_normal(1'b1);
            // New rate crosses two sync stages and the rate register
            repeat (4) @(posedge clk);
            chk("par_valid", 8'h01, {7'h0, par_valid});
            rd(8'h3B, {1'b0, rates[i], 4'h0});
            rd(8'h3C, 8'h0E);
        end
        $display("test rate and lock done");
        wr(8'h2E, 8'h02);
        errs(2, 0);
        rd(8'h3E, 8'h02);
        rd(8'h3F, 8'h00);
        wr(8'h2D, 8'h08);
        errs(1, 1);
        rd(8'h3E, 8'h02);
        chk("link_acq", 8'h01, {7'h0, link_acq});
        wr(8'h2D, 8'h00);
        errs(1, 1);
        wait_normal(1'b0);
        chk("par_valid", 8'h00, {7'h0, par_valid});
        chk("link_acq", 8'h00, {7'h0, link_acq});
        rd(8'h3D, 8'h01);
        $display("test threshold done");
        wr(8'h2D, 8'h04);
        rd(8'h3E, 8'h00);
        rd(8'h3F, 8'h00);
        wr(8'h2D, 8'h00);
        wait_normal(1'b1);
        wr(8'h2D, 8'h01);
        errs(3, 0);
        repeat (6) @(posedge clk);
        wait_normal(1'b1);
        rd(8'h3E, 8'h03);
        wr(8'h3E, 8'h00);
        wr(8'h2D, 8'h00);
        $display("test clear and exit disable done");
        errs(1, 0);
        fe_u.pulse(2);
        errs(1, 0);
        wr(8'h2D, 8'h02);
        rd(8'h3E, 8'h01);
        wr(8'h2D, 8'h00);
        rd(8'h3E, 8'h02);
        $display("test count select done");
        wr(8'h2D, 8'h10);
        evt_sel = 1'b0;
        fe_u.set_lock(1'b0, 3'h7);
        wait_normal(1'b0);
        rd(8'h3D, 8'h01);
        fe_u.set_lock(1'b1, 3'h6);
        wait_normal(1'b1);
        rd(8'h3E, 8'h02);
        evt_en = 1'b0;
        fe_u.set_lock(1'b0, 3'h7);
        wait_normal(1'b0);
        rd(8'h3D, 8'h01);
        $display("test accumulate and events done");
        report_and_stop;
    end
endmodule
